/* sim/sensor_pin_model.sv */
// Sensor comparators and the pulled-up overheat wire beside the block
`timescale 1ns/1ps
module sensor_pin_model (
    input wire logic i_clk_sys,
    input wire logic i_arst_n,
    input wire logic i_heat,
    input wire logic i_ext_drive,
    input wire logic i_pin_n_out,
    input wire logic i_pin_oe,
    output logic o_hot,
    output logic o_cool,
    output logic o_pin_n
);
    // Fixed trip; cool trails hot by a cycle to leave a release band
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n)
            {o_hot, o_cool} <= 2'b01;
        else
            {o_hot, o_cool} <= {i_heat, !i_heat && !o_hot};
    end
    assign o_pin_n = !((i_pin_oe && !i_pin_n_out)
                       || i_ext_drive);
endmodule

/* sim/tb_top.sv */
// Self-checking bench for the thermal clock throttle
`timescale 1ns/1ps
`include "throttle_consts.svh"
module tb_top;
    logic i_clk_sys, i_arst_n, i_wr, i_rd, i_snoop_req, i_irq, heat, ext;
    logic [3:0] i_addr;
    logic [7:0] i_wdata, o_rdata;
    logic i_sensor_hot, i_sensor_cool, i_overheat_indicator_n, pin_n, pin_oe;
    logic o_snoop_ack, o_irq_core, o_core_clk_en, act;
    logic [31:0] rnd = 32'hb079;
    int fail_count, check_count, cyc, n;
    thermal_clock_throttle u_dut (.i_clk_sys, .i_arst_n, .i_addr, .i_wdata,
        .i_wr, .i_rd, .o_rdata, .i_sensor_hot, .i_sensor_cool,
        .i_overheat_indicator_n, .o_overheat_indicator_n(pin_n),
        .o_overheat_indicator_oe(pin_oe), .i_snoop_req, .o_snoop_ack, .i_irq,
        .o_irq_core, .o_core_clk_en, .o_thermal_control_circuit_active(act));
    sensor_pin_model u_model (.i_clk_sys, .i_arst_n, .i_heat(heat),
        .i_ext_drive(ext), .i_pin_n_out(pin_n), .i_pin_oe(pin_oe),
        .o_hot(i_sensor_hot), .o_cool(i_sensor_cool),
        .o_pin_n(i_overheat_indicator_n));
    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    function automatic logic [7:0] rb(input logic [3:0] a, input logic [7:0] d);
        case (a)
            `THR_OFF_MODE: return d & 8'h01;
            `THR_OFF_DEMAND: return d & 8'h1e;
            `THR_OFF_PERIOD: return d;
            default: return 8'h00;
        endcase
    endfunction
    task check(input logic ok, input string m);
        check_count++;
        if (ok !== 1'b1) begin
            fail_count++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask
    task conclude;
        if (fail_count == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task tick(input int k);
        repeat (k) @(posedge i_clk_sys);
        #1;
    endtask
    task wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_clk_sys);
        {i_addr, i_wdata, i_wr} <= {a, d, 1'b1};
        @(posedge i_clk_sys);
        i_wr <= 1'b0;
    endtask
    task rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge i_clk_sys);
        {i_addr, i_rd} <= {a, 1'b1};
        @(posedge i_clk_sys);
        i_rd <= 1'b0;
        #1 check(o_rdata === e, "readback");
    endtask
    // Any whole modulation period holds duty times slot-length on cycles
    task count(input int len, input bit sel);
        n = 0;
        repeat (len) begin
            @(posedge i_clk_sys);
            #1 n += ((sel ? o_irq_core : o_core_clk_en) === 1'b1);
        end
    endtask
    initial begin
        i_clk_sys = 1'b0;
        forever #5 i_clk_sys = ~i_clk_sys;
    end
    always @(posedge i_clk_sys) begin
        rnd <= xs(rnd);
        i_snoop_req <= i_arst_n & rnd[3];
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            conclude();
        end
    end
    initial begin
        logic [3:0] a;
        logic [7:0] d;
        {i_arst_n, i_wr, i_rd, i_snoop_req, i_irq, heat, ext} = 7'h00;
        {i_addr, i_wdata} = 12'h000;
        repeat (2) @(posedge i_clk_sys);
        i_arst_n <= 1'b1;
        for (int i = 0; i < 16; i++)
            rd(i[3:0], i == 3 ? `THR_PERIOD_RST : 8'h00);
        repeat (12) begin
            {a, d} = rnd[11:0];
            if (a != `THR_OFF_STATUS) begin
                wr(a, d);
                rd(a, rb(a, d));
            end
        end
        wr(`THR_OFF_DEMAND, 8'h00);
        wr(`THR_OFF_PERIOD, 8'h04);
        wr(`THR_OFF_MODE, 8'h00);
        @(posedge i_clk_sys) heat <= 1'b1;
        tick(10);
        check(act === 1'b0, "auto off");
        check(i_overheat_indicator_n === 1'b0, "pin");
        wr(`THR_OFF_MODE, 8'h01);
        tick(6);
        check(act === 1'b1, "no trip");
        // Demand with duty one eighth must not disturb the fixed half duty
        wr(`THR_OFF_DEMAND, 8'h12);
        tick(32);
        count(32, 0);
        check(n === 16, "auto duty");
        wr(`THR_OFF_PERIOD, 8'h02);
        tick(16);
        count(16, 0);
        check(n === 8, "period");
        for (int k = 0; k < 40 && o_core_clk_en === 1'b1; k++)
            tick(1);
        @(posedge i_clk_sys) i_irq <= 1'b1;
        @(posedge i_clk_sys) i_irq <= 1'b0;
        count(40, 1);
        check(n > 0, "irq lost");
        wr(`THR_OFF_DEMAND, 8'h00);
        @(posedge i_clk_sys) heat <= 1'b0;
        tick(12);
        check(act === 1'b1, "early release");
        tick(30);
        check(act === 1'b0 && o_core_clk_en === 1'b1, "stuck");
        wr(`THR_OFF_MODE, 8'h00);
        for (int k = 0; k < 8; k++) begin
            wr(`THR_OFF_DEMAND, {4'h1, k[2:0], 1'b0});
            tick(16);
            count(16, 0);
            check(n === 2 * k, "demand duty");
        end
        wr(`THR_OFF_DEMAND, 8'h00);
        wr(`THR_OFF_MODE, 8'h01);
        @(posedge i_clk_sys) ext <= 1'b1;
        tick(8);
        check(act === 1'b1, "ext pin");
        conclude();
    end
endmodule

/* sim/thermal_clock_throttle_assertions.sv */
// Port checker for the thermal clock throttle
`timescale 1ns/1ps
`include "throttle_consts.svh"
module throttle_checker (
    input wire logic i_clk_sys,
    input wire logic i_arst_n,
    input wire logic [3:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [7:0] o_rdata,
    input wire logic i_sensor_hot,
    input wire logic i_sensor_cool,
    input wire logic o_overheat_indicator_n,
    input wire logic i_snoop_req,
    input wire logic o_snoop_ack,
    input wire logic o_irq_core,
    input wire logic o_core_clk_en,
    input wire logic o_thermal_control_circuit_active
);
    logic auto_en;
    wire logic act = o_thermal_control_circuit_active;
    wire logic dem_wr = i_wr && i_addr == `THR_OFF_DEMAND;
    // Shadow of the mode bit, taken from the same write strobe
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n)
            auto_en <= 1'b0;
        else if (i_wr && i_addr == `THR_OFF_MODE)
            auto_en <= i_wdata[`THR_MODE_AUTO_BIT];
    end
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_arst_n);
    a_snoop_kept: assert property
        ($past(i_arst_n, 3) |-> o_snoop_ack == $past(i_snoop_req, 3))
        else $error("snoop ack");
    a_irq_gated: assert property
        (o_irq_core |-> o_core_clk_en) else $error("irq while gated");
    a_gate_cause: assert property
        (!o_core_clk_en |-> act) else $error("gated while idle");
    a_auto_trip: assert property
        ((auto_en && i_sensor_hot) [*5] |-> act) else $error("no auto trip");
    a_demand_now: assert property
        (dem_wr && i_wdata[`THR_DEM_EN_BIT] |-> ##3 act) else $error("demand");
    a_hyst_hold: assert property
        ((auto_en && !i_sensor_cool) [*5] ##0 act |=> act) else $error("hyst");
    a_pin_hot: assert property
        (i_sensor_hot [*4] |-> !o_overheat_indicator_n) else $error("pin");
    a_rdata_zero: assert property
        (!$past(i_rd) |-> o_rdata == 8'h00) else $error("rdata idle");
    c_engage: cover property ($rose(act));
    c_gate: cover property ($fell(o_core_clk_en));
    c_irq: cover property (act && o_irq_core);
endmodule
bind thermal_clock_throttle throttle_checker u_chk (.i_clk_sys, .i_arst_n,
    .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_sensor_hot, .i_sensor_cool,
    .o_overheat_indicator_n, .i_snoop_req, .o_snoop_ack, .o_irq_core,
    .o_core_clk_en, .o_thermal_control_circuit_active);

/* verilog/duty_modulator.sv */
// Eighths-based clock-on/off modulator for the throttle block
`timescale 1ns/1ps
`include "throttle_consts.svh"

module duty_modulator (
    input wire logic i_clk_sys,
    input wire logic i_arst_n,
    input wire logic i_run,
    input wire logic [2:0] i_duty,
    input wire logic [7:0] i_slot_len,
    output logic o_clk_on
);

    logic [7:0] slot_cnt;
    logic [2:0] eighth;
    logic [7:0] slot_last;
    logic slot_end;
    logic next_on;

    // Slot length counted in core cycles keeps the period proportional
    // to the core period, so it shrinks as frequency rises.
    assign slot_last = (i_slot_len == 8'h00) ? 8'h00 : i_slot_len - 8'h01;
    assign slot_end = (slot_cnt >= slot_last);
    assign next_on = i_run && (eighth < i_duty);

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            slot_cnt <= 8'h00;
            eighth <= 3'h0;
        end else if (!i_run) begin
            slot_cnt <= 8'h00;
            eighth <= 3'h0;
        end else if (slot_end) begin
            slot_cnt <= 8'h00;
            eighth <= eighth + 3'h1;
        end else begin
            slot_cnt <= slot_cnt + 8'h01;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_clk_on <= 1'b1;
        end else begin
            o_clk_on <= next_on || !i_run;
        end
    end

endmodule

/* verilog/thermal_clock_throttle.sv */
// Thermal clock throttle: automatic and on-demand core clock modulation
// Function
// - Trip point fixed, no software setting
// - Snoops keep flowing while throttling
// - Interrupts latched, delivered while clocks run
// - Over temperature gates core clocks repeatedly
// - Automatic mode wins over on-demand
// - Mode chosen through model-specific registers
// - Automatic engages only at maximum temperature; here an outside pull on the indicator also engages it
// - Automatic duty is half on, half off
// - Period scales with core clock period
// - Cooling stops gating, circuit goes idle; here it passes to on-demand instead when that is enabled
// - Hysteresis prevents rapid toggling
// - Automatic duty fixed, writes ignored
// - Automatic mode runs purely in hardware
// - On-demand enable engages immediately
// - Overheat indicator driven low when hot
// - External overheat drive engages throttling
`timescale 1ns/1ps
`include "throttle_consts.svh"

module thermal_clock_throttle (
    input wire logic i_clk_sys,
    input wire logic i_arst_n,
    input wire logic [3:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    input wire logic i_sensor_hot,
    input wire logic i_sensor_cool,
    input wire logic i_overheat_indicator_n,
    output logic o_overheat_indicator_n,
    output logic o_overheat_indicator_oe,
    input wire logic i_snoop_req,
    output logic o_snoop_ack,
    input wire logic i_irq,
    output logic o_irq_core,
    output logic o_core_clk_en,
    output logic o_thermal_control_circuit_active
);

    throttle_pkg::reg_req_t req;
    throttle_pkg::sensor_t sens_meta;
    throttle_pkg::sensor_t sens;
    throttle_pkg::thr_state_t state;
    throttle_pkg::thr_state_t next_state;

    logic ext_meta;
    logic ext_hot;
    logic irq_meta;
    logic irq_sync;
    logic snoop_meta;
    logic snoop_sync;

    logic [7:0] mode_reg;
    logic [7:0] demand_reg;
    logic [7:0] period_reg;
    logic [7:0] next_rdata;
    logic [7:0] status_word;

    logic auto_en;
    logic demand_en;
    logic [2:0] demand_duty;
    logic hot_req;
    logic cool_ok;
    logic [7:0] cool_cnt;
    logic cool_held;
    logic irq_pend;
    logic [2:0] duty_sel;
    logic run_mod;
    logic clk_on;
    logic sel_mode;
    logic sel_demand;
    logic sel_status;
    logic sel_period;
    logic wr_mode;
    logic wr_demand;
    logic wr_period;
    logic gate_open;
    logic irq_deliver;

    assign req = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

    // Pins pass two flops before any logic sees them; only the second
    // flop of each pair is read, so a metastable first stage stays hidden
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            sens_meta <= '0;
            sens <= '0;
        end else begin
            sens_meta <= '{hot: i_sensor_hot, cool: i_sensor_cool};
            sens <= sens_meta;
        end
    end

    // Indicator pin is active low; kept as a high-true flag inside.
    // Reset matches the released pin, so no false hot follows reset.
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ext_meta <= 1'b0;
            ext_hot <= 1'b0;
        end else begin
            ext_meta <= !i_overheat_indicator_n;
            ext_hot <= ext_meta;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            irq_meta <= 1'b0;
            irq_sync <= 1'b0;
        end else begin
            irq_meta <= i_irq;
            irq_sync <= irq_meta;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            snoop_meta <= 1'b0;
            snoop_sync <= 1'b0;
        end else begin
            snoop_meta <= i_snoop_req;
            snoop_sync <= snoop_meta;
        end
    end

    // Register decode
    assign sel_mode = (req.addr == `THR_OFF_MODE);
    assign sel_demand = (req.addr == `THR_OFF_DEMAND);
    assign sel_status = (req.addr == `THR_OFF_STATUS);
    assign sel_period = (req.addr == `THR_OFF_PERIOD);

    // Trip level comes only from the comparator; no register holds it
    assign auto_en = mode_reg[`THR_MODE_AUTO_BIT];
    assign demand_en = demand_reg[`THR_DEM_EN_BIT];
    assign demand_duty = demand_reg[`THR_DEM_DUTY_MSB:`THR_DEM_DUTY_LSB];

    assign status_word = {2'h0,
                          state == throttle_pkg::ST_AUTO,
                          irq_pend,
                          ext_hot,
                          sens.hot,
                          !clk_on,
                          state != throttle_pkg::ST_IDLE};

    assign next_rdata = sel_mode ? mode_reg :
                        sel_demand ? demand_reg :
                        sel_status ? status_word :
                        sel_period ? period_reg : 8'h00;

    assign wr_mode = req.wr && sel_mode;
    assign wr_demand = req.wr && sel_demand;
    assign wr_period = req.wr && sel_period;

    // Only the enable bit is kept; the rest reads back as zero
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            mode_reg <= `THR_MODE_RST;
        end else if (wr_mode) begin
            mode_reg <= {7'h00, req.wdata[`THR_MODE_AUTO_BIT]};
        end
    end

    // Enable and duty land together, so a new duty never runs disabled
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            demand_reg <= `THR_DEMAND_RST;
        end else if (wr_demand) begin
            demand_reg <= {3'h0,
                           req.wdata[`THR_DEM_EN_BIT:`THR_DEM_DUTY_LSB],
                           1'b0};
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            period_reg <= `THR_PERIOD_RST;
        end else if (wr_period) begin
            period_reg <= req.wdata;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_rdata <= 8'h00;
        end else begin
            o_rdata <= req.rd ? next_rdata : 8'h00;
        end
    end

    // Hot when sensor trips or an outside agent pulls the indicator
    assign hot_req = sens.hot || ext_hot;

    // Release needs the cool comparator and a held-off time; the
    // separate cool threshold plus the delay form the hysteresis band.
    assign cool_ok = sens.cool && !hot_req;
    assign cool_held = (cool_cnt >= 8'(`THR_HYST_CYC));

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cool_cnt <= 8'h00;
        end else if (!cool_ok) begin
            cool_cnt <= 8'h00;
        end else if (!cool_held) begin
            cool_cnt <= cool_cnt + 8'h01;
        end
    end

    // Automatic mode is checked first, so it governs when both apply
    always_comb begin
        next_state = state;
        case (state)
            throttle_pkg::ST_IDLE: begin
                if (auto_en && hot_req)
                    next_state = throttle_pkg::ST_AUTO;
                else if (demand_en)
                    next_state = throttle_pkg::ST_DEMAND;
            end
            throttle_pkg::ST_AUTO: begin
                if (!auto_en)
                    next_state = demand_en ? throttle_pkg::ST_DEMAND
                                           : throttle_pkg::ST_IDLE;
                else if (cool_held)
                    next_state = demand_en ? throttle_pkg::ST_DEMAND
                                           : throttle_pkg::ST_IDLE;
            end
            throttle_pkg::ST_DEMAND: begin
                if (auto_en && hot_req)
                    next_state = throttle_pkg::ST_AUTO;
                else if (!demand_en)
                    next_state = throttle_pkg::ST_IDLE;
            end
            default: next_state = throttle_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state <= throttle_pkg::ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Automatic duty is a constant; software cannot reach it
    assign duty_sel = (state == throttle_pkg::ST_AUTO) ? `THR_AUTO_DUTY
                      : demand_duty;
    assign run_mod = (state != throttle_pkg::ST_IDLE);

    duty_modulator u_mod (
        .i_clk_sys(i_clk_sys),
        .i_arst_n(i_arst_n),
        .i_run(run_mod),
        .i_duty(duty_sel),
        .i_slot_len(period_reg),
        .o_clk_on(clk_on)
    );

    // The modulator output lags the run flag by one cycle, so leaving the
    // throttle could hold the core stopped for one more cycle; the gate
    // is forced open whenever the circuit is idle.
    assign gate_open = clk_on || !run_mod;
    assign irq_deliver = (irq_pend || irq_sync) && gate_open;

    // Interrupts wait while clocks are gated; set wins over delivery
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            irq_pend <= 1'b0;
        end else if (irq_sync) begin
            irq_pend <= 1'b1;
        end else if (gate_open) begin
            irq_pend <= 1'b0;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_irq_core <= 1'b0;
        end else begin
            o_irq_core <= irq_deliver;
        end
    end

    // Snoop path ignores the gate so coherency never stalls
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_snoop_ack <= 1'b0;
        end else begin
            o_snoop_ack <= snoop_sync;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_core_clk_en <= 1'b1;
        end else begin
            o_core_clk_en <= gate_open;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_thermal_control_circuit_active <= 1'b0;
        end else begin
            o_thermal_control_circuit_active <= run_mod;
        end
    end

    // Indicator follows our own sensor only, so an outside pull cannot
    // keep us driving the pin once the die has cooled
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_overheat_indicator_n <= 1'b1;
        end else begin
            o_overheat_indicator_n <= !sens.hot;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_overheat_indicator_oe <= 1'b0;
        end else begin
            o_overheat_indicator_oe <= sens.hot;
        end
    end

endmodule

/* verilog/throttle_consts.svh */
// Constants for the thermal clock throttle block
`ifndef THROTTLE_CONSTS_SVH
`define THROTTLE_CONSTS_SVH

// Register offsets on the plain register port
`define THR_OFF_MODE 4'h0
`define THR_OFF_DEMAND 4'h1
`define THR_OFF_STATUS 4'h2
`define THR_OFF_PERIOD 4'h3

// Mode register fields
`define THR_MODE_AUTO_BIT 0

// On-demand register fields
`define THR_DEM_EN_BIT 4
`define THR_DEM_DUTY_LSB 1
`define THR_DEM_DUTY_MSB 3

// Status register fields
`define THR_ST_ACTIVE_BIT 0
`define THR_ST_GATE_BIT 1
`define THR_ST_HOT_BIT 2
`define THR_ST_EXTHOT_BIT 3
`define THR_ST_PEND_BIT 4
`define THR_ST_AUTO_BIT 5

// Reset values
`define THR_MODE_RST 8'h00
`define THR_DEMAND_RST 8'h00
`define THR_PERIOD_RST 8'h10

// Fixed automatic duty: four eighths on
`define THR_AUTO_DUTY 3'h4

// Hysteresis: cool level must hold this many ns before release, rounded up to 10 ns cycles
`define THR_HYST_NS 200
`define THR_HYST_CYC ((`THR_HYST_NS + 9) / 10)

`endif

/* verilog/throttle_pkg.sv */
// Types shared by the thermal clock throttle block
package throttle_pkg;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_AUTO,
        ST_DEMAND
    } thr_state_t;

    typedef struct packed {
        logic hot;
        logic cool;
    } sensor_t;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

endpackage
